/* File: sim/srss_checker.sv */
// port checker of the supply, reset and sleep supervisor
`timescale 1ns/1ns
module srss_checker (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // watched inputs
  input wire logic        logic_supply_ok_i,
  input wire logic [2:0]  load_supply_ok_i,
  input wire logic        pump_uv_ok_i,
  input wire logic        battery_ov_i,
  input wire logic        reset_pin_n_i,
  input wire logic        enable_pin_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  // watched outputs
  input wire logic [15:0] reg_rdata_o,
  input wire logic [2:0]  channel_on_o,
  input wire logic        fault_pin_n_oe_o,
  input wire logic        internal_reset_o,
  input wire logic        sleep_o,
  input wire logic        iface_ready_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int unsigned hold_q;
  // length of the running reset stretch; [*6] below covers sync latency
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) hold_q <= 0;
    else hold_q <= internal_reset_o ? hold_q + 1 : 0;
  end
  property p_pin; !reset_pin_n_i [*6] |-> internal_reset_o; endproperty
  a_pin: assert property (p_pin) else $error("pin low, no reset");
  property p_core; !logic_supply_ok_i [*6] |-> internal_reset_o && sleep_o;
  endproperty
  a_core: assert property (p_core) else $error("supply low, no sleep");
  property p_uv; !load_supply_ok_i[1] [*6] |-> !channel_on_o[1]; endproperty
  a_uv: assert property (p_uv) else $error("channel on in uv");
  property p_pump;
    !pump_uv_ok_i [*6] |-> channel_on_o == 3'h0 && fault_pin_n_oe_o;
  endproperty
  a_pump: assert property (p_pump) else $error("pump uv ignored");
  property p_bat;
    battery_ov_i [*6] |-> channel_on_o == 3'h0 && fault_pin_n_oe_o;
  endproperty
  a_bat: assert property (p_bat) else $error("battery ov ignored");
  property p_en; !enable_pin_i [*6] |-> channel_on_o == 3'h0; endproperty
  a_en: assert property (p_en) else $error("channel on, enable low");
  property p_rflt; internal_reset_o |-> fault_pin_n_oe_o; endproperty
  a_rflt: assert property (p_rflt) else $error("reset, fault off");
  property p_por;
    $fell(internal_reset_o) |-> hold_q >= srss_pkg::POR_PIN_CYCLES;
  endproperty
  a_por: assert property (p_por) else $error("interval short");
  property p_id;
    iface_ready_o && reg_rd_i && reg_addr_i == srss_pkg::OFS_IDENT
      |=> reg_rdata_o == srss_pkg::IDENT_VAL;
  endproperty
  a_id: assert property (p_id) else $error("ident wrong");
  c_run: cover property ($fell(internal_reset_o));
  c_all: cover property (channel_on_o == 3'h7);
  c_slp: cover property ($rose(sleep_o));
endmodule

bind srss_top srss_checker chk_u (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .logic_supply_ok_i(logic_supply_ok_i),
  .load_supply_ok_i(load_supply_ok_i), .pump_uv_ok_i(pump_uv_ok_i),
  .battery_ov_i(battery_ov_i), .reset_pin_n_i(reset_pin_n_i),
  .enable_pin_i(enable_pin_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .channel_on_o(channel_on_o), .fault_pin_n_oe_o(fault_pin_n_oe_o),
  .internal_reset_o(internal_reset_o), .sleep_o(sleep_o),
  .iface_ready_o(iface_ready_o)
);

/* File: sim/srss_clk_src.sv */
// host-side external clock source, one edge pulse per period
`timescale 1ns/1ns
module srss_clk_src #(
  parameter int unsigned DIV = 5
) (
  // clock
  input  wire logic sys_clk_i,
  // bench stops the clock to provoke a loss
  input  wire logic run_i,
  // edge pulse
  output logic      ext_clk_edge_o
);
  int unsigned cnt_q = 0;
  // counter runs on while stopped; only the edge output is gated, no stray edge
  always @(posedge sys_clk_i) begin
    cnt_q <= (cnt_q == DIV - 1) ? 0 : cnt_q + 1;
    ext_clk_edge_o <= run_i && cnt_q == 0;
  end
endmodule

/* File: sim/srss_top_tb.sv */
// self-checking bench of the supply, reset and sleep supervisor
`timescale 1ns/1ns
module srss_top_tb;
  localparam logic [3:0] A_ST = srss_pkg::OFS_STATUS;
  localparam logic [3:0] A_CT = srss_pkg::OFS_CONTROL;
  localparam logic [3:0] A_SP = srss_pkg::OFS_SETPT;
  localparam logic [15:0] ID = srss_pkg::IDENT_VAL;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  core = 3'h7;
  logic [2:0]  load = 3'h7;
  logic        pump_ok = 1'b1;
  logic        warn_ok = 1'b1;
  logic        bat_ov = 1'b0;
  logic        pin_n = 1'b1;
  logic        en = 1'b1;
  logic        clk_run = 1'b1;
  logic        ext_edge;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0]  ch;
  logic        oe;
  logic        fpin;
  logic        irst;
  logic        slp;
  logic        rdy;
  int          miscompares = 0;
  int          n_tests = 0;

  // 50 MHz system clock
  initial forever #10 sys_clk_i = ~sys_clk_i;

  srss_clk_src src_u (.sys_clk_i(sys_clk_i), .run_i(clk_run),
    .ext_clk_edge_o(ext_edge));
  srss_top dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .logic_supply_ok_i(core[0]), .analog_supply_ok_i(core[1]),
    .reference_supply_ok_i(core[2]), .load_supply_ok_i(load),
    .pump_uv_ok_i(pump_ok), .pump_warn_ok_i(warn_ok),
    .battery_ov_i(bat_ov), .reset_pin_n_i(pin_n), .enable_pin_i(en),
    .ext_clk_edge_i(ext_edge), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .channel_on_o(ch), .fault_pin_n_o(fpin), .fault_pin_n_oe_o(oe),
    .internal_reset_o(irst), .sleep_o(slp), .iface_ready_o(rdy));

  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // let the edge's updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrt(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [15:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task automatic wait_rdy(output int n);
    n = 0;
    while (rdy !== 1'b1) begin
      if (n > 70000) begin
        miscompares++;
        wrap_up();
      end
      cyc(1);
      n++;
    end
  endtask

  task automatic t_power_up();
    int n;
    wait_rdy(n);
    chk("por_len", 16'h1, 16'(n >= srss_pkg::POR_UV_CYCLES));
    rchk("rst_flag", A_ST, 16'h0020);
    rchk("rst_clr", A_ST, 16'h0000);
    wrt(A_CT, 16'h0003);
    wrt(A_SP, 16'h0007);
    cyc(3);
    chk("ch_run", 16'h7, 16'(ch));
    chk("oe_run", 16'h0, 16'(oe));
  endtask
  task automatic t_load_uv();
    @(posedge sys_clk_i) load <= 3'h5;
    cyc(6);
    chk("ch_uv", 16'h5, 16'(ch));
    chk("oe_nomask", 16'h0, 16'(oe));
    rchk("uv_flag", A_ST, 16'h0002);
    wrt(A_CT, 16'h000b);
    cyc(3);
    chk("oe_mask", 16'h1, 16'(oe));
    @(posedge sys_clk_i) load <= 3'h7;
    wrt(A_CT, 16'h0003);
    cyc(6);
    chk("ch_back", 16'h7, 16'(ch));
  endtask
  task automatic t_pump();
    @(posedge sys_clk_i) warn_ok <= 1'b0;
    cyc(6);
    chk("ch_warn", 16'h7, 16'(ch));
    rchk("warn_flag", A_ST, 16'h0010);
    @(posedge sys_clk_i) pump_ok <= 1'b0;
    cyc(6);
    chk("ch_pump", 16'h0, 16'(ch));
    chk("oe_pump", 16'h1, 16'(oe));
    rchk("pump_flag", A_ST, 16'h0018);
    @(posedge sys_clk_i) pump_ok <= 1'b1;
    warn_ok <= 1'b1;
    @(posedge sys_clk_i) bat_ov <= 1'b1;
    cyc(6);
    chk("ch_bat", 16'h0, 16'(ch));
    chk("oe_bat", 16'h1, 16'(oe));
    @(posedge sys_clk_i) bat_ov <= 1'b0;
  endtask
  task automatic t_enable();
    @(posedge sys_clk_i) en <= 1'b0;
    cyc(6);
    chk("ch_en", 16'h0, 16'(ch));
    chk("oe_fme", 16'h1, 16'(oe));
    rchk("sp_clr", A_SP, 16'h0000);
    wrt(A_CT, 16'h0001);
    cyc(3);
    chk("oe_nofme", 16'h0, 16'(oe));
    @(posedge sys_clk_i) en <= 1'b1;
    cyc(6);
    chk("ch_stay", 16'h0, 16'(ch));
    wrt(A_SP, 16'h0007);
    cyc(3);
    chk("ch_set", 16'h7, 16'(ch));
  endtask
  task automatic t_pin_reset();
    int n;
    @(posedge sys_clk_i) pin_n <= 1'b0;
    cyc(6);
    chk("rst_pin", 16'h1, 16'(irst));
    chk("oe_pin", 16'h1, 16'(oe));
    chk("fpin", 16'h0, 16'(fpin));
    rchk("rd_off", srss_pkg::OFS_IDENT, 16'h0000);
    @(posedge sys_clk_i) pin_n <= 1'b1;
    wait_rdy(n);
    chk("pin_len", 16'h1, 16'(n >= 5000 && n <= 5010));
    rchk("rst_again", A_ST, 16'h0020);
  endtask
  task automatic t_clk_loss();
    wrt(A_CT, 16'h0001);
    @(posedge sys_clk_i) clk_run <= 1'b0;
    cyc(120);
    chk("rst_wd", 16'h1, 16'(irst));
    rchk("id_st", A_ST, ID);
    wrt(A_SP, 16'h0007);
    rchk("id_sp", A_SP, ID);
    chk("ch_wd", 16'h0, 16'(ch));
    @(posedge sys_clk_i) clk_run <= 1'b1;
  endtask
  // each core rail in turn; full wake interval is too long to rerun
  task automatic t_sleep();
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i) core <= 3'h7 & ~(3'h1 << i);
      cyc(6);
      chk("sleep", 16'h1, 16'(slp));
      chk("slp_rst", 16'h1, 16'(irst));
      @(posedge sys_clk_i) core <= 3'h7;
      cyc(6);
      chk("wake", 16'h0, 16'(slp));
      chk("wake_rst", 16'h1, 16'(irst));
    end
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_power_up();
    t_load_uv();
    t_pump();
    t_enable();
    t_pin_reset();
    t_clk_loss();
    t_sleep();
    wrap_up();
  end
endmodule

/* File: verilog/srss_pkg.sv */
// package of constants for the supply, reset and sleep supervisor
package srss_pkg;
  // ------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------
  localparam int unsigned NUM_CH = 3;

  // ------------------------------------------------------------------
  // register offsets (word index on the plain port)
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS  = 4'h0; // fault status, clears rst flag
  localparam logic [3:0] OFS_CONTROL = 4'h1; // watchdog enable, masks
  localparam logic [3:0] OFS_SETPT   = 4'h2; // channel enable bits
  localparam logic [3:0] OFS_IDENT   = 4'h3; // identification register

  // ------------------------------------------------------------------
  // status field positions
  // ------------------------------------------------------------------
  localparam int unsigned ST_UV_LSB   = 0;  // load undervoltage flags 2:0
  localparam int unsigned ST_PUMP_UV  = 3;
  localparam int unsigned ST_PUMP_W   = 4;
  localparam int unsigned ST_RESET    = 5;
  localparam int unsigned ST_WDOG     = 6;

  // control field positions
  localparam int unsigned CT_CLOCK_WATCHDOG_ENABLE     = 0;
  localparam int unsigned CT_FME      = 1;
  localparam int unsigned CT_FM_LSB   = 2;  // channel masks 4:2

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [4:0] CONTROL_RST = 5'h00;
  localparam logic [2:0] SETPT_RST   = 3'h0;
  // identification value is arbitrary
  localparam logic [15:0] IDENT_VAL  = 16'h5a01;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned POR_UV_CYCLES  = 65536;
  localparam real         POR_PIN_MS     = 0.1;
  // longest time rounds down: 0.1 ms at 50 MHz
  localparam int unsigned POR_PIN_CYCLES =
    int'($floor(POR_PIN_MS * 1000.0 * CLK_MHZ));
  localparam real         CLK_LOSS_US    = 2.0;
  localparam int unsigned CLK_LOSS_CYCLES =
    int'($ceil(CLK_LOSS_US * CLK_MHZ));

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_HOLD,
    ST_POR,
    ST_RUN
  } srss_state_e;
endpackage

/* File: verilog/srss_sync.sv */
// two-flop synchroniser bank for the asynchronous comparator inputs
`timescale 1ns/1ns
module srss_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

/* File: verilog/srss_top.sv */
// supply, reset and sleep supervisor of a three-channel solenoid driver
// Functional notes
// - load undervoltage disables that channel and sets its flag
// - any core supply comparator low holds logic in reset
// - with watchdog enabled, missing clock holds reset
// - release only after supplies good and reset interval elapsed
// - interval counter starts first cycle after reset pin rises
// - leaving reset sets the reset-occurred flag
// - any status access clears the reset-occurred flag
// - pump undervoltage disables outputs and sets pump undervoltage flag
// - pump below warning sets warning flag, operation continues
// - any core supply low enters sleep
// - sleep exits automatically when all core supplies good
// - sleep exit acts as full reset including interval
// - channels run only if every condition good, else fault low
// - enable pin low disables channels; fault low only if mask set
// - channel load undervoltage drives fault only if channel mask set
// - after watchdog timeout reads return ident, writes refused
// - reset pin low holds reset, fault low, interface off; after a watchdog timeout the interface stays on until the pin rises or a core supply drops
// - interval 65536 cycles from undervoltage, 0.1 ms from pin
// - enable pin low clears channel enables; they stay until written
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module srss_top (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // supply comparators, high when rail is good; battery_ov_i is high on overvoltage
  input  wire logic        logic_supply_ok_i,
  input  wire logic        analog_supply_ok_i,
  input  wire logic        reference_supply_ok_i,
  input  wire logic [2:0]  load_supply_ok_i,
  input  wire logic        pump_uv_ok_i,
  input  wire logic        pump_warn_ok_i,
  input  wire logic        battery_ov_i,
  // pins
  input  wire logic        reset_pin_n_i,
  input  wire logic        enable_pin_i,
  input  wire logic        ext_clk_edge_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // outputs
  output logic [2:0]       channel_on_o,
  output logic             fault_pin_n_o,
  output logic             fault_pin_n_oe_o,
  output logic             internal_reset_o,
  output logic             sleep_o,
  output logic             iface_ready_o
);
  // ------------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------------
  localparam int unsigned NS = 11;
  logic [NS-1:0] raw_w;
  logic [NS-1:0] syn_w;

  assign raw_w = {battery_ov_i, pump_warn_ok_i, pump_uv_ok_i,
                  load_supply_ok_i, reference_supply_ok_i,
                  analog_supply_ok_i, logic_supply_ok_i,
                  reset_pin_n_i, enable_pin_i};

  srss_sync #(.W(NS)) u_sync (
    .clk_i (sys_clk_i),
    .rst_i (rst_i),
    .d_i   (raw_w),
    .q_o   (syn_w)
  );

  wire       en_pin_w   = syn_w[0];
  wire       rstpin_w   = syn_w[1];
  wire       core_ok_w  = &syn_w[4:2];
  wire [2:0] load_ok_w  = syn_w[7:5];
  wire       pump_ok_w  = syn_w[8];
  wire       warn_ok_w  = syn_w[9];
  wire       bat_ov_w   = syn_w[10];

  // ------------------------------------------------------------------
  // clock loss watchdog
  // ------------------------------------------------------------------
  logic [7:0] loss_cnt_q;
  logic       wdog_q;
  logic       clock_watchdog_enable_q;
  logic       rstpin_d1_q;
  wire        pin_rise_w = rstpin_w & ~rstpin_d1_q;
  wire        clk_lost_w =
    (loss_cnt_q >= 8'(srss_pkg::CLK_LOSS_CYCLES));

  // counts system cycles between external clock edges
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      loss_cnt_q <= 8'h00;
    end else if (ext_clk_edge_i) begin
      loss_cnt_q <= 8'h00;
    end else if (!clk_lost_w) begin
      loss_cnt_q <= loss_cnt_q + 8'h01;
    end
  end

  // timeout latches until reset pin rises or supplies drop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_q      <= 1'b0;
      rstpin_d1_q <= 1'b0;
    end else begin
      rstpin_d1_q <= rstpin_w;
      if (!core_ok_w || pin_rise_w) begin
        wdog_q <= 1'b0;
      end else if (clock_watchdog_enable_q && clk_lost_w) begin
        wdog_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // reset and sleep sequencer
  // ------------------------------------------------------------------
  srss_pkg::srss_state_e state_q;
  srss_pkg::srss_state_e state_d;
  logic [16:0] por_cnt_q;
  logic        por_long_q;
  logic        por_done_w;
  wire         hold_w = !rstpin_w || wdog_q;

  // recovery from undervoltage uses the long interval
  assign por_done_w = por_long_q ?
    (por_cnt_q >= 17'(srss_pkg::POR_UV_CYCLES - 1)) :
    (por_cnt_q >= 17'(srss_pkg::POR_PIN_CYCLES - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      srss_pkg::ST_SLEEP: begin
        if (core_ok_w) state_d = srss_pkg::ST_HOLD;
      end
      srss_pkg::ST_HOLD: begin
        if (!core_ok_w) state_d = srss_pkg::ST_SLEEP;
        else if (!hold_w) state_d = srss_pkg::ST_POR;
      end
      srss_pkg::ST_POR: begin
        if (!core_ok_w) state_d = srss_pkg::ST_SLEEP;
        else if (hold_w) state_d = srss_pkg::ST_HOLD;
        else if (por_done_w) state_d = srss_pkg::ST_RUN;
      end
      srss_pkg::ST_RUN: begin
        if (!core_ok_w) state_d = srss_pkg::ST_SLEEP;
        else if (hold_w) state_d = srss_pkg::ST_HOLD;
      end
      default: state_d = srss_pkg::ST_SLEEP;
    endcase
  end

  wire in_reset_w  = (state_q != srss_pkg::ST_RUN);
  wire leaving_w   = (state_q == srss_pkg::ST_POR) &&
                     (state_d == srss_pkg::ST_RUN);
  // registers return to reset values whenever not running
  wire soft_rst_w  = (state_d != srss_pkg::ST_RUN) && in_reset_w;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= srss_pkg::ST_SLEEP;
      por_cnt_q  <= 17'h00000;
      por_long_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (state_q != srss_pkg::ST_POR) begin
        por_cnt_q <= 17'h00000;
      end else if (!por_done_w) begin
        por_cnt_q <= por_cnt_q + 17'h00001;
      end
      // remember whether the last reset came from undervoltage
      if (state_q == srss_pkg::ST_SLEEP) begin
        por_long_q <= 1'b1;
      end else if (state_q == srss_pkg::ST_RUN) begin
        por_long_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------------
  wire acc_ok_w = !in_reset_w || wdog_q;
  wire wr_ok_w  = reg_wr_i && !in_reset_w && !wdog_q;
  wire wr_ctl_w = wr_ok_w && (reg_addr_i == srss_pkg::OFS_CONTROL);
  wire wr_sp_w  = wr_ok_w && (reg_addr_i == srss_pkg::OFS_SETPT);
  wire st_acc_w = (reg_rd_i || reg_wr_i) && !in_reset_w && !wdog_q &&
                  (reg_addr_i == srss_pkg::OFS_STATUS);

  logic [4:0] ctl_q;
  logic [2:0] setpt_q;
  logic [2:0] uv_flag_q;
  logic       pump_uv_q;
  logic       pump_w_q;
  logic       rst_flag_q;

  always_comb clock_watchdog_enable_q = ctl_q[srss_pkg::CT_CLOCK_WATCHDOG_ENABLE];
  wire       fme_w  = ctl_q[srss_pkg::CT_FME];
  wire [2:0] fm_w   = ctl_q[srss_pkg::CT_FM_LSB +: 3];

  // control register, back to reset values while in reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_q <= srss_pkg::CONTROL_RST;
    end else if (soft_rst_w) begin
      ctl_q <= srss_pkg::CONTROL_RST;
    end else if (wr_ctl_w) begin
      ctl_q <= reg_wdata_i[4:0];
    end
  end

  // channel enables: pin low forces clear, host must rewrite
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      setpt_q <= srss_pkg::SETPT_RST;
    end else if (soft_rst_w || !en_pin_w) begin
      setpt_q <= srss_pkg::SETPT_RST;
    end else if (wr_sp_w) begin
      setpt_q <= reg_wdata_i[2:0];
    end
  end

  // fault flags follow the inputs; reset flag set wins over the clear by access
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_flag_q  <= 3'h0;
      pump_uv_q  <= 1'b0;
      pump_w_q   <= 1'b0;
      rst_flag_q <= 1'b0;
    end else if (soft_rst_w) begin
      uv_flag_q  <= 3'h0;
      pump_uv_q  <= 1'b0;
      pump_w_q   <= 1'b0;
      rst_flag_q <= 1'b0;
    end else begin
      uv_flag_q  <= ~load_ok_w;
      pump_uv_q  <= ~pump_ok_w;
      pump_w_q   <= ~warn_ok_w;
      if (leaving_w) begin
        rst_flag_q <= 1'b1;
      end else if (st_acc_w) begin
        rst_flag_q <= 1'b0;
      end
    end
  end

  wire [15:0] status_w = {9'h000, wdog_q, rst_flag_q, pump_w_q,
                          pump_uv_q, uv_flag_q};

  // read mux; a tripped watchdog answers ident to every read
  logic [15:0] rd_mux_w;
  always_comb begin
    rd_mux_w = 16'h0000;
    if (wdog_q) begin
      rd_mux_w = srss_pkg::IDENT_VAL;
    end else begin
      case (reg_addr_i)
        srss_pkg::OFS_STATUS:  rd_mux_w = status_w;
        srss_pkg::OFS_CONTROL: rd_mux_w = {11'h000, ctl_q};
        srss_pkg::OFS_SETPT:   rd_mux_w = {13'h0000, setpt_q};
        srss_pkg::OFS_IDENT:   rd_mux_w = srss_pkg::IDENT_VAL;
        default:               rd_mux_w = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // channel gating and fault pin
  // ------------------------------------------------------------------
  // watchdog must be enabled before outputs may run
  wire        glob_ok_w = !in_reset_w && en_pin_w && pump_ok_w &&
                          !bat_ov_w && clock_watchdog_enable_q && !clk_lost_w;
  wire [2:0]  ch_on_w   = {3{glob_ok_w}} & load_ok_w & setpt_q;
  wire        ch_fault_w = |(~load_ok_w & fm_w);
  // next state, so the pin is pulled in step with internal reset
  wire        fault_w   = (state_d != srss_pkg::ST_RUN) || clk_lost_w ||
                          !pump_ok_w || bat_ov_w ||
                          (!en_pin_w && fme_w) || ch_fault_w;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o      <= 16'h0000;
      channel_on_o     <= 3'h0;
      fault_pin_n_o    <= 1'b0;
      fault_pin_n_oe_o <= 1'b1;
      internal_reset_o <= 1'b1;
      sleep_o          <= 1'b1;
      iface_ready_o    <= 1'b0;
    end else begin
      reg_rdata_o      <= (reg_rd_i && acc_ok_w) ? rd_mux_w : 16'h0000;
      channel_on_o     <= ch_on_w;
      fault_pin_n_o    <= 1'b0;
      fault_pin_n_oe_o <= fault_w; // open drain: drive low on fault
      internal_reset_o <= (state_d != srss_pkg::ST_RUN);
      sleep_o          <= (state_d == srss_pkg::ST_SLEEP);
      iface_ready_o    <= (state_d == srss_pkg::ST_RUN) || wdog_q;
    end
  end
endmodule
